// file: logic/drpc_pkg.sv
// Purpose: Constants for the dual receiver port control register bank
// Assumes: 8-bit register port fed by the I2C target logic
// Notes: Offsets are the byte addresses the host puts on the port

package drpc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DRPC_OFS_DUAL_RX = 8'h34;
  localparam logic [7:0] DRPC_OFS_EQ_CTL = 8'h35;
  localparam logic [7:0] DRPC_OFS_STRAP = 8'h37;
  localparam logic [7:0] DRPC_OFS_DIVSEL = 8'h3a;
  localparam logic [7:0] DRPC_OFS_EQ_STAT = 8'h3b;
  localparam logic [7:0] DRPC_OFS_EQ_FLOOR = 8'h45;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] DRPC_RST_DUAL_RX = 8'h01;
  localparam logic [7:0] DRPC_RST_EQ_CTL = 8'h00;
  localparam logic [7:0] DRPC_RST_DIVSEL = 8'h00;
  localparam logic [3:0] DRPC_RST_FLOOR = 4'h8;
  localparam logic [5:0] DRPC_RST_VCO_DIV = 6'h20;
  localparam logic [3:0] DRPC_RST_REF_DIV = 4'h1;
  localparam logic [7:0] DRPC_WM_DUAL_RX = 8'h7b;
  localparam logic [7:0] DRPC_WM_EQ_CTL = 8'h70;
  localparam logic [7:0] DRPC_WM_DIVSEL = 8'hf7;
  localparam logic [7:0] DRPC_WM_FLOOR = 8'h0f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DRPC_B_LOCK_MODE = 6;
  localparam int DRPC_B_RAW_BC = 5;
  localparam int DRPC_B_INMODE_HI = 4;
  localparam int DRPC_B_INMODE_LO = 3;
  localparam int DRPC_B_SECOND_SEL = 1;
  localparam int DRPC_B_FIRST_SEL = 0;
  localparam int DRPC_B_EQ_RESTART = 6;
  localparam int DRPC_B_FLOOR_OVR = 5;
  localparam int DRPC_B_FLOOR_APPLY = 4;
  localparam int DRPC_B_VCO_OVR = 7;
  localparam int DRPC_B_VCO_HI = 6;
  localparam int DRPC_B_VCO_LO = 4;
  localparam int DRPC_B_REF_OVR = 2;
  localparam int DRPC_B_REF_HI = 1;
  localparam int DRPC_B_REF_LO = 0;

  // ----------------------------------------------------------------
  // Receive input selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DRPC_IN_AUTO = 2'h0;
  localparam logic [1:0] DRPC_IN_DUAL = 2'h1;
  localparam logic [1:0] DRPC_IN_PRIMARY = 2'h2;
  localparam logic [1:0] DRPC_IN_SECONDARY = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DRPC_CLK_PERIOD_NS = 100;
  localparam int DRPC_STRAP_SETTLE_NS = 1000;
  localparam int DRPC_STRAP_SETTLE_CYC =
    (DRPC_STRAP_SETTLE_NS + DRPC_CLK_PERIOD_NS - 1) / DRPC_CLK_PERIOD_NS;
  localparam logic [7:0] DRPC_STRAP_CNT_END =
    8'(DRPC_STRAP_SETTLE_CYC);

endpackage : drpc_pkg

// file: logic/drpc_strap_decode.sv
// Purpose: Latch one strap pin decode after a settle time past reset
// Assumes: Level input already digitised to three bits, synchronous
// Notes: Result is frozen until the next reset

module drpc_strap_decode
  import drpc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Strap level
  input wire logic [2:0] level_i,
  // Latched result
  output logic [2:0] code_o,
  output logic done_o
);

  logic [7:0] settle_q;

  // ----------------------------------------------------------------
  // Settle counter, started at reset release
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      settle_q <= 8'h00;
    else if (settle_q != DRPC_STRAP_CNT_END)
      settle_q <= settle_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // Capture once; level taken by clock, never by the reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_o <= 3'h0;
      done_o <= 1'b0;
    end
    else if (!done_o && settle_q == DRPC_STRAP_CNT_END)
    begin
      code_o <= level_i;
      done_o <= 1'b1;
    end
  end

endmodule : drpc_strap_decode

// file: logic/drpc_regs.sv
// Purpose: Dual receiver port control and status registers
// Assumes: Byte register port driven by the I2C target, one clock
// Notes: Equalizer control and floor have one copy per receive port

// Contract
// - Policy 0: lock shown only while active video, video-off flag low.
// - Policy 1: lock shown whenever linked, even control channel only.
// - Raw mode passes back-channel GPIO zero straight to remote side.
// - Input selection: 00 auto, 01 dual, 10 primary, 11 secondary.
// - Second-port select: writes hit second copy; reads return it.
// - Both selects set: reads return second port; host clears second select to read first.
// - First-port select resets to 1; writes and reads first copy.
// - Restart bit high restarts both ports; host writes high then low.
// - Floor apply acts only with override enable; uses level at 0x45.
// - Done flag per strap sets once decode is latched.
// - Strap one decode in bits 6-4, strap zero in bits 2-0.
// - Divider override 1 uses programmed VCO divide, else not overridden.
// - VCO divide codes: 32,16,8,4,2,2,1,1.
// - Reference override 0 lets PLL machine choose, 1 uses register.
// - Reference divide codes: 1,2,4,8.
// - Video-off flag is 1 when no active video yet link is up.
// - Floor level is four bits, resets to 8h, adaptation start point.
module drpc_regs
  import drpc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Link status
  input wire logic linked_i,
  input wire logic video_off_i,
  input wire logic detected_dual_i,
  output logic rx_lock_o,
  // Back channel
  input wire logic backchannel_gpio_zero_i,
  input wire logic filtered_bc_i,
  output logic bc_out_o,
  // Receive input selection
  output logic dual_link_o,
  output logic use_primary_o,
  output logic use_secondary_o,
  // Equalizer
  input wire logic [5:0] eq_status_i,
  output logic eq_restart_o,
  output logic [1:0] floor_apply_o,
  output logic [3:0] floor_level0_o,
  output logic [3:0] floor_level1_o,
  // Straps
  input wire logic [2:0] strap_zero_level_i,
  input wire logic [2:0] strap_one_level_i,
  // Audio clock PLL
  input wire logic [5:0] pll_auto_vco_div_i,
  input wire logic [3:0] pll_auto_ref_div_i,
  output logic [5:0] vco_div_o,
  output logic [3:0] ref_div_o
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] vco_ratio(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h01;
    case (code)
      3'h0: r = 6'h20;
      3'h1: r = 6'h10;
      3'h2: r = 6'h08;
      3'h3: r = 6'h04;
      3'h4, 3'h5: r = 6'h02;
      default: r = 6'h01;
    endcase
    return r;
  endfunction : vco_ratio

  function automatic logic [3:0] ref_ratio(input logic [1:0] code);
    return 4'(4'h1 << code);
  endfunction : ref_ratio

  // Masked merge so reserved bits never change
  function automatic logic [7:0] merge(input logic [7:0] old,
    input logic [7:0] wd, input logic [7:0] wm);
    return (old & ~wm) | (wd & wm);
  endfunction : merge

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] dual_rx_q;
  logic [7:0] divsel_q;
  logic [7:0] eq_ctl_q [2];
  logic [7:0] floor_q [2];
  logic [7:0] rdata_d;
  logic [2:0] strap0_code;
  logic [2:0] strap1_code;
  logic strap0_done;
  logic strap1_done;
  logic first_sel;
  logic second_sel;
  logic rd_second;
  logic [1:0] in_mode;

  assign first_sel = dual_rx_q[DRPC_B_FIRST_SEL];
  assign second_sel = dual_rx_q[DRPC_B_SECOND_SEL];
  assign in_mode = dual_rx_q[DRPC_B_INMODE_HI:DRPC_B_INMODE_LO];
  // Second port wins a read when both are selected
  assign rd_second = second_sel;

  // ----------------------------------------------------------------
  // Shared registers
  // ----------------------------------------------------------------
  // first select reset
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dual_rx_q <= DRPC_RST_DUAL_RX;
      divsel_q <= DRPC_RST_DIVSEL;
    end
    else if (reg_wr_i && reg_addr_i == DRPC_OFS_DUAL_RX)
      dual_rx_q <= merge(dual_rx_q, reg_wdata_i, DRPC_WM_DUAL_RX);
    else if (reg_wr_i && reg_addr_i == DRPC_OFS_DIVSEL)
      divsel_q <= merge(divsel_q, reg_wdata_i, DRPC_WM_DIVSEL);
  end

  // ----------------------------------------------------------------
  // Per-port copies; a write lands in every selected copy
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      eq_ctl_q[0] <= DRPC_RST_EQ_CTL;
      eq_ctl_q[1] <= DRPC_RST_EQ_CTL;
      floor_q[0] <= {4'h0, DRPC_RST_FLOOR};
      floor_q[1] <= {4'h0, DRPC_RST_FLOOR};
    end
    else if (reg_wr_i)
    begin
      if (first_sel && reg_addr_i == DRPC_OFS_EQ_CTL)
        eq_ctl_q[0] <= merge(eq_ctl_q[0], reg_wdata_i, DRPC_WM_EQ_CTL);
      if (first_sel && reg_addr_i == DRPC_OFS_EQ_FLOOR)
        floor_q[0] <= merge(floor_q[0], reg_wdata_i, DRPC_WM_FLOOR);
      if (second_sel && reg_addr_i == DRPC_OFS_EQ_CTL)
        eq_ctl_q[1] <= merge(eq_ctl_q[1], reg_wdata_i, DRPC_WM_EQ_CTL);
      if (second_sel && reg_addr_i == DRPC_OFS_EQ_FLOOR)
        floor_q[1] <= merge(floor_q[1], reg_wdata_i, DRPC_WM_FLOOR);
    end
  end

  // ----------------------------------------------------------------
  // Strap decoders
  // ----------------------------------------------------------------
  drpc_strap_decode u_strap0 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .level_i(strap_zero_level_i),
    .code_o(strap0_code),
    .done_o(strap0_done)
  );

  drpc_strap_decode u_strap1 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .level_i(strap_one_level_i),
    .code_o(strap1_code),
    .done_o(strap1_done)
  );

  // ----------------------------------------------------------------
  // Read mux; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_addr_i == DRPC_OFS_DUAL_RX)
      rdata_d = dual_rx_q;
    else if (reg_addr_i == DRPC_OFS_EQ_CTL)
      rdata_d = rd_second ? eq_ctl_q[1] : eq_ctl_q[0];
    else if (reg_addr_i == DRPC_OFS_STRAP)
      rdata_d = {strap1_done, strap1_code, strap0_done, strap0_code};
    else if (reg_addr_i == DRPC_OFS_DIVSEL)
      rdata_d = divsel_q;
    else if (reg_addr_i == DRPC_OFS_EQ_STAT)
      rdata_d = {2'h0, eq_status_i};
    else if (reg_addr_i == DRPC_OFS_EQ_FLOOR)
      rdata_d = rd_second ? floor_q[1] : floor_q[0];
  end

  // Read data held until the next read
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_d;
  end

  // ----------------------------------------------------------------
  // Link lock and back channel
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_lock_o <= 1'b0;
      bc_out_o <= 1'b0;
    end
    else
    begin
      rx_lock_o <= linked_i &&
        (dual_rx_q[DRPC_B_LOCK_MODE] || !video_off_i);
      bc_out_o <= dual_rx_q[DRPC_B_RAW_BC] ? backchannel_gpio_zero_i
                                            : filtered_bc_i;
    end
  end

  // ----------------------------------------------------------------
  // Receive input mode
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dual_link_o <= 1'b0;
      use_primary_o <= 1'b0;
      use_secondary_o <= 1'b0;
    end
    else
    begin
      case (in_mode)
        DRPC_IN_DUAL:
        begin
          dual_link_o <= 1'b1;
          use_primary_o <= 1'b1;
          use_secondary_o <= 1'b1;
        end
        DRPC_IN_PRIMARY:
        begin
          dual_link_o <= 1'b0;
          use_primary_o <= 1'b1;
          use_secondary_o <= 1'b0;
        end
        DRPC_IN_SECONDARY:
        begin
          dual_link_o <= 1'b0;
          use_primary_o <= 1'b0;
          use_secondary_o <= 1'b1;
        end
        default:
        begin
          // Auto: follow what the incoming data says
          dual_link_o <= detected_dual_i;
          use_primary_o <= 1'b1;
          use_secondary_o <= detected_dual_i;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Equalizer controls
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      eq_restart_o <= 1'b0;
      floor_apply_o <= 2'h0;
      floor_level0_o <= DRPC_RST_FLOOR;
      floor_level1_o <= DRPC_RST_FLOOR;
    end
    else
    begin
      eq_restart_o <= eq_ctl_q[0][DRPC_B_EQ_RESTART] ||
                      eq_ctl_q[1][DRPC_B_EQ_RESTART];
      floor_apply_o[0] <= eq_ctl_q[0][DRPC_B_FLOOR_OVR] &&
                          eq_ctl_q[0][DRPC_B_FLOOR_APPLY];
      floor_apply_o[1] <= eq_ctl_q[1][DRPC_B_FLOOR_OVR] &&
                          eq_ctl_q[1][DRPC_B_FLOOR_APPLY];
      floor_level0_o <= floor_q[0][3:0];
      floor_level1_o <= floor_q[1][3:0];
    end
  end

  // ----------------------------------------------------------------
  // Audio clock PLL dividers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vco_div_o <= DRPC_RST_VCO_DIV;
      ref_div_o <= DRPC_RST_REF_DIV;
    end
    else
    begin
      vco_div_o <= divsel_q[DRPC_B_VCO_OVR]
        ? vco_ratio(divsel_q[DRPC_B_VCO_HI:DRPC_B_VCO_LO])
        : pll_auto_vco_div_i;
      ref_div_o <= divsel_q[DRPC_B_REF_OVR]
        ? ref_ratio(divsel_q[DRPC_B_REF_HI:DRPC_B_REF_LO])
        : pll_auto_ref_div_i;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_lock_video;
    !dual_rx_q[DRPC_B_LOCK_MODE] && video_off_i |=> !rx_lock_o;
  endproperty
  a_lock_video: assert property (p_lock_video)
    else $error("lock shown without active video");

  property p_lock_linked;
    dual_rx_q[DRPC_B_LOCK_MODE] && linked_i |=> rx_lock_o;
  endproperty
  a_lock_linked: assert property (p_lock_linked)
    else $error("lock missing while linked");

  property p_raw_bc;
    dual_rx_q[DRPC_B_RAW_BC] |=> bc_out_o == $past(backchannel_gpio_zero_i);
  endproperty
  a_raw_bc: assert property (p_raw_bc)
    else $error("raw back channel not passed through");

  property p_in_secondary;
    in_mode == DRPC_IN_SECONDARY |=>
      !dual_link_o && !use_primary_o && use_secondary_o;
  endproperty
  a_in_secondary: assert property (p_in_secondary)
    else $error("secondary input mode wrong");

  property p_second_write;
    reg_wr_i && second_sel && reg_addr_i == DRPC_OFS_EQ_FLOOR |=>
      ##1 floor_level1_o == $past(reg_wdata_i[3:0], 2);
  endproperty
  a_second_write: assert property (p_second_write)
    else $error("second port floor copy not written");

  property p_both_read;
    reg_rd_i && first_sel && second_sel && !reg_wr_i &&
      reg_addr_i == DRPC_OFS_EQ_FLOOR |=> reg_rdata_o == $past(floor_q[1]);
  endproperty
  a_both_read: assert property (p_both_read)
    else $error("read did not return second port");

  property p_first_write;
    reg_wr_i && first_sel && reg_addr_i == DRPC_OFS_EQ_FLOOR |=>
      ##1 floor_level0_o == $past(reg_wdata_i[3:0], 2);
  endproperty
  a_first_write: assert property (p_first_write)
    else $error("first port floor copy not written");

  property p_restart;
    eq_ctl_q[1][DRPC_B_EQ_RESTART] |=> eq_restart_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart not driven");

  property p_floor_gate;
    !eq_ctl_q[0][DRPC_B_FLOOR_OVR] |=> !floor_apply_o[0];
  endproperty
  a_floor_gate: assert property (p_floor_gate)
    else $error("floor applied without override");

  property p_strap_done;
    strap0_done |=> strap0_done && $stable(strap0_code);
  endproperty
  a_strap_done: assert property (p_strap_done)
    else $error("strap result changed after done");

  property p_vco_div;
    divsel_q[DRPC_B_VCO_OVR] && divsel_q[6:4] == 3'h0 |=> vco_div_o == 6'h20;
  endproperty
  a_vco_div: assert property (p_vco_div)
    else $error("VCO divide not 32");

  property p_ref_div;
    !divsel_q[DRPC_B_REF_OVR] |=> ref_div_o == $past(pll_auto_ref_div_i);
  endproperty
  a_ref_div: assert property (p_ref_div)
    else $error("reference divide overridden while off");

  property p_reserved;
    reg_rd_i && reg_addr_i == DRPC_OFS_DUAL_RX |=> !reg_rdata_o[7];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit read non-zero");

  c_both_sel: cover property (first_sel && second_sel);
  c_strap_done: cover property (strap0_done && strap1_done);
  c_lock_ctrl_only: cover property (rx_lock_o && video_off_i);

endmodule : drpc_regs

// file: test/drpc_host.sv
// Purpose: Host model driving the byte register port
// Assumes: Strobes launched after a falling edge, taken at rising edge
// Notes: Released address and data are inverted so stale values never match

module drpc_host
  import drpc_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Register port
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle port at time zero
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end

  // One write strobe, held across exactly one rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr_reg

  // One read strobe; data is registered, so taken half a cycle later
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge mclk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask : rd_reg

endmodule : drpc_host

// file: test/dual_receiver_port_control_regs_tb.sv
// Purpose: Self-checking bench for the port control register bank
// Assumes: Inputs change on falling edges, outputs sampled there too
// Notes: Strap levels are fixed for the run, latched once after reset

module dual_receiver_port_control_regs_tb
  import drpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk_i, rst_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
  logic linked_i, video_off_i, detected_dual_i, rx_lock_o;
  logic backchannel_gpio_zero_i, filtered_bc_i, bc_out_o;
  logic dual_link_o, use_primary_o, use_secondary_o, eq_restart_o;
  logic [5:0] eq_status_i, pll_auto_vco_div_i, vco_div_o;
  logic [1:0] floor_apply_o;
  logic [3:0] floor_level0_o, floor_level1_o, pll_auto_ref_div_i, ref_div_o;
  logic [2:0] strap_zero_level_i, strap_one_level_i;
  logic [2:0] mode_exp [4];
  int bad_count, n_tests;

  drpc_regs DUT (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .linked_i(linked_i),
    .video_off_i(video_off_i), .detected_dual_i(detected_dual_i),
    .rx_lock_o(rx_lock_o), .backchannel_gpio_zero_i(backchannel_gpio_zero_i),
    .filtered_bc_i(filtered_bc_i), .bc_out_o(bc_out_o),
    .dual_link_o(dual_link_o), .use_primary_o(use_primary_o),
    .use_secondary_o(use_secondary_o), .eq_status_i(eq_status_i),
    .eq_restart_o(eq_restart_o), .floor_apply_o(floor_apply_o),
    .floor_level0_o(floor_level0_o), .floor_level1_o(floor_level1_o),
    .strap_zero_level_i(strap_zero_level_i),
    .strap_one_level_i(strap_one_level_i),
    .pll_auto_vco_div_i(pll_auto_vco_div_i),
    .pll_auto_ref_div_i(pll_auto_ref_div_i),
    .vco_div_o(vco_div_o), .ref_div_o(ref_div_o));

  drpc_host host (.mclk_i(mclk_i), .reg_addr_o(reg_addr_i),
    .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o));

  // ------------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------------
  // Case inequality so an unknown never passes
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Read one register and compare its byte
  task automatic rchk(logic [7:0] a, logic [7:0] exp);
    host.rd_reg(a, rd);
    chk($sformatf("reg %h", a), rd, exp);
  endtask : rchk

  // Outputs are registered one edge after their cause
  task automatic settle;
    repeat (2) @(negedge mclk_i);
  endtask : settle

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Free-running 10 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // Watchdog, far beyond the roughly 180 cycles the tests need
  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial
  begin
    bad_count = 0;
    n_tests = 0;
    rst_i = 1'b1;
    linked_i = 1'b0;
    video_off_i = 1'b1;
    detected_dual_i = 1'b1;
    backchannel_gpio_zero_i = 1'b1;
    filtered_bc_i = 1'b0;
    eq_status_i = 6'h2a;
    strap_zero_level_i = 3'h5;
    strap_one_level_i = 3'h3;
    pll_auto_vco_div_i = 6'h0c;
    pll_auto_ref_div_i = 4'h3;
    mode_exp = '{3'h7, 3'h7, 3'h2, 3'h1};
    repeat (3) @(negedge mclk_i);
    rst_i = 1'b0;

    // Reset values, strap fields still empty
    rchk(8'h37, 8'h00);
    rchk(8'h34, 8'h01);
    rchk(8'h35, 8'h00);
    rchk(8'h3a, 8'h00);
    rchk(8'h45, 8'h08);
    chk("floor level0", {4'h0, floor_level0_o}, 8'h08);
    $display("test reset done");

    // Strap decode latched after the settle time, read-only
    repeat (12) @(negedge mclk_i);
    rchk(8'h37, 8'hbd);
    host.wr_reg(8'h37, 8'h00);
    rchk(8'h37, 8'hbd);
    $display("test straps done");

    // Reserved bits, unmapped offset, status byte
    host.wr_reg(8'h34, 8'hff);
    rchk(8'h34, 8'h7b);
    host.wr_reg(8'h35, 8'hff);
    rchk(8'h35, 8'h70);
    host.wr_reg(8'h35, 8'h00);
    host.wr_reg(8'h50, 8'h55);
    rchk(8'h50, 8'h00);
    rchk(8'h3b, 8'h2a);
    $display("test reserved done");

    // Lock policy
    host.wr_reg(8'h34, 8'h01);
    linked_i = 1'b1;
    settle();
    chk("lock policy0 off", {7'h0, rx_lock_o}, 8'h00);
    video_off_i = 1'b0;
    settle();
    chk("lock policy0 on", {7'h0, rx_lock_o}, 8'h01);
    video_off_i = 1'b1;
    host.wr_reg(8'h34, 8'h41);
    settle();
    chk("lock policy1 on", {7'h0, rx_lock_o}, 8'h01);
    linked_i = 1'b0;
    settle();
    chk("lock policy1 off", {7'h0, rx_lock_o}, 8'h00);
    $display("test lock done");

    // Raw back channel against filtered path
    host.wr_reg(8'h34, 8'h21);
    settle();
    chk("raw bc high", {7'h0, bc_out_o}, 8'h01);
    backchannel_gpio_zero_i = 1'b0;
    filtered_bc_i = 1'b1;
    settle();
    chk("raw bc low", {7'h0, bc_out_o}, 8'h00);
    host.wr_reg(8'h34, 8'h01);
    settle();
    chk("filtered bc", {7'h0, bc_out_o}, 8'h01);
    $display("test backchannel done");

    // Every receive input code, outputs as {dual, primary, secondary}
    for (int i = 0; i < 4; i++)
    begin
      host.wr_reg(8'h34, 8'(i * 8 + 1));
      settle();
      chk("input mode", {5'h0, dual_link_o, use_primary_o, use_secondary_o},
        {5'h0, mode_exp[i]});
    end
    host.wr_reg(8'h34, 8'h01);
    detected_dual_i = 1'b0;
    settle();
    chk("auto single", {5'h0, dual_link_o, use_primary_o, use_secondary_o},
      8'h02);
    $display("test input mode done");

    // Port copies selected for access
    host.wr_reg(8'h45, 8'h05);
    settle();
    chk("floor level0", {4'h0, floor_level0_o}, 8'h05);
    host.wr_reg(8'h34, 8'h02);
    host.wr_reg(8'h45, 8'h0a);
    settle();
    chk("floor level1", {4'h0, floor_level1_o}, 8'h0a);
    chk("floor level0 kept", {4'h0, floor_level0_o}, 8'h05);
    rchk(8'h45, 8'h0a);
    host.wr_reg(8'h34, 8'h03);
    rchk(8'h45, 8'h0a);
    // Second select cleared before reading the first copy
    host.wr_reg(8'h34, 8'h01);
    rchk(8'h45, 8'h05);
    $display("test port select done");

    // Floor apply gating and restart level
    host.wr_reg(8'h35, 8'h10);
    settle();
    chk("apply no override", {6'h0, floor_apply_o}, 8'h00);
    host.wr_reg(8'h35, 8'h30);
    settle();
    chk("apply override", {6'h0, floor_apply_o}, 8'h01);
    // Restart written high then low
    host.wr_reg(8'h35, 8'h40);
    settle();
    chk("restart high", {7'h0, eq_restart_o}, 8'h01);
    rchk(8'h35, 8'h40);
    host.wr_reg(8'h35, 8'h00);
    settle();
    chk("restart low", {7'h0, eq_restart_o}, 8'h00);
    $display("test equalizer done");

    // Every divider code with both overrides set, reserved bit 3 written
    for (int i = 0; i < 8; i++)
    begin
      host.wr_reg(8'h3a, {1'b1, 3'(i), 2'h3, 2'(i)});
      settle();
      rchk(8'h3a, {1'b1, 3'(i), 2'h1, 2'(i)});
      chk("vco div", {2'h0, vco_div_o},
        (i > 5) ? 8'h01 : (i > 3) ? 8'h02 : 8'h20 >> i);
      chk("ref div", {4'h0, ref_div_o}, 8'h01 << (i % 4));
    end
    host.wr_reg(8'h3a, 8'h00);
    settle();
    chk("vco no override", {2'h0, vco_div_o}, 8'h0c);
    chk("ref no override", {4'h0, ref_div_o}, 8'h03);
    $display("test dividers done");

    print_verdict();
  end

endmodule : dual_receiver_port_control_regs_tb
